/* pmcrb_defines.svh */
// offsets, field positions, masks and reset values of the register bank
`ifndef PMCRB_DEFINES_SVH
`define PMCRB_DEFINES_SVH
// register offsets
`define PMCRB_OFS_DEV_ID     8'h00
`define PMCRB_OFS_OTP_VER    8'h01
`define PMCRB_OFS_SW0_CTRL   8'h02
`define PMCRB_OFS_PG_CTRL1   8'h15
`define PMCRB_OFS_PG_CTRL2   8'h16
`define PMCRB_OFS_POWER_GOOD_FAULT_FLAGS   8'h17
`define PMCRB_OFS_SW_RESET   8'h18
`define PMCRB_OFS_INT_TOP1   8'h19
`define PMCRB_OFS_INT_TOP2   8'h1a
`define PMCRB_OFS_INT_SW     8'h1b
`define PMCRB_OFS_INT_LIN    8'h1c
`define PMCRB_OFS_STAT_TOP   8'h1d
`define PMCRB_OFS_STAT_SW    8'h1e
`define PMCRB_OFS_STAT_LIN   8'h1f
`define PMCRB_OFS_MASK_TOP1  8'h20
`define PMCRB_OFS_MASK_TOP2  8'h21
`define PMCRB_OFS_MASK_SW    8'h22
`define PMCRB_OFS_MASK_LIN   8'h23
`define PMCRB_OFS_ILOAD_SEL  8'h24
`define PMCRB_OFS_ILOAD_HI   8'h25
`define PMCRB_OFS_ILOAD_LO   8'h26
// implemented bits of each register, reserved bits are zero
`define PMCRB_MSK_DEV_ID     8'hc0
`define PMCRB_MSK_SW0_CTRL   8'h0f
`define PMCRB_MSK_PG_CTRL1   8'hdf
`define PMCRB_MSK_PG_CTRL2   8'h07
`define PMCRB_MSK_POWER_GOOD_FAULT_FLAGS   8'h0f
`define PMCRB_MSK_SW_RESET   8'h01
`define PMCRB_MSK_INT_TOP1   8'hff
`define PMCRB_MSK_BIT0       8'h01
`define PMCRB_MSK_INT_CH     8'h77
`define PMCRB_MSK_STAT_TOP   8'h86
`define PMCRB_MSK_STAT_CH    8'hdd
`define PMCRB_MSK_MASK_TOP1  8'h95
`define PMCRB_MSK_ALL        8'hff
`define PMCRB_MSK_NONE       8'h00
// field positions in the switcher 0 control and identification registers
`define PMCRB_BIT_FPWM       3
`define PMCRB_BIT_DISCH      2
`define PMCRB_BIT_ENSRC      1
`define PMCRB_BIT_SWEN       0
`define PMCRB_POS_ID_LSB     6
// reset values before the otp copy
`define PMCRB_RST_SW0_CTRL   4'h7
`define PMCRB_RST_OTHER      8'h00
`define PMCRB_RST_ILOAD_SEL  1'b0
`endif

/* pmcrb_host_model.sv */
// host side model issuing register accesses behind the serial engine
`timescale 1ns/1ps
module pmcrb_host_model (
  input wire logic clk_i, // bus clock
  output pmcrb_pkg::pmcrb_req_type req_o, // register access
  input wire logic [7:0] rdata_i, // read data
  input wire logic rvalid_i // read data valid pulse
);
  import pmcrb_pkg::*;
  // idle at time zero with both strobes low
  initial begin
    req_o = '0;
  end
  // one write, then release with inverted fields so stale data never helps
  task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    #1 req_o = '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
    @(posedge clk_i);
    #1 req_o = '{addr: ~a, wr: 1'b0, rd: 1'b0, wdata: ~d};
  endtask
  // one read, answer sampled in the single cycle the valid pulse stands
  task automatic read_reg(input logic [7:0] a, output logic [7:0] d,
                          output logic v);
    @(posedge clk_i);
    #1 req_o = '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h5a};
    @(posedge clk_i);
    #1 v = rvalid_i;
    d = rdata_i;
    req_o = '{addr: ~a, wr: 1'b0, rd: 1'b0, wdata: 8'ha5};
  endtask
endmodule

/* pmcrb_pkg.sv */
// types shared by the register bank and its surroundings
package pmcrb_pkg;
  // one access from the serial interface byte engine
  typedef struct packed {
    logic [7:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } pmcrb_req_type;
  // regulator state reported by the analog side
  typedef struct packed {
    logic [7:0] top;
    logic [7:0] sw;
    logic [7:0] lin;
    logic [3:0] power_good_fault_flags;
    logic [8:0] iload;
  } pmcrb_stat_type;
  // one-cycle event pulses that set sticky flags
  typedef struct packed {
    logic [7:0] top1;
    logic top2;
    logic [7:0] sw;
    logic [7:0] lin;
  } pmcrb_evt_type;
  // defaults copied out of one-time memory
  typedef struct packed {
    logic [3:0] sw0_ctrl;
    logic [7:0] version;
  } pmcrb_otp_type;
endpackage

/* pmcrb_top.sv */
// control and status register bank of the dual switcher power device
// How it works
// - two-bit part code, top bits, read-only
// - eight-bit otp version code, read-only
// - forced pwm bit holds switcher in pwm
// - discharge resistor applied while switcher disabled
// - source bit adds enable pin to control
// - software enable bit turns switcher on
// - registers reached over the serial interface
// - otp read loads marked register defaults
`timescale 1ns/1ps
`include "pmcrb_defines.svh"
module pmcrb_top #(
  parameter logic [1:0] PART_ID = 2'h1 // arbitrary value
) (
  input wire logic MCLK_I, // 250 MHz clock
  input wire logic RESET_I, // synchronous reset, high
  input wire logic CE_I, // clock enable, freezes all state
  input wire pmcrb_pkg::pmcrb_req_type REQ_I, // register access
  output logic [7:0] RDATA_O, // read data
  output logic RVALID_O, // read data valid pulse
  input wire logic OTP_LOAD_I, // otp read state strobe
  input wire pmcrb_pkg::pmcrb_otp_type OTP_I, // otp defaults
  input wire pmcrb_pkg::pmcrb_stat_type STAT_I, // live status
  input wire pmcrb_pkg::pmcrb_evt_type EVT_I, // event pulses
  input wire logic EN_PIN_I, // external enable pin
  output logic SW0_FORCED_PWM_O, // switcher 0 held in pwm
  output logic SW0_ENABLE_O, // switcher 0 running
  output logic SW0_DISCHARGE_O, // discharge resistor connected
  output logic [7:0] PG_CTRL1_O, // power good control first
  output logic [2:0] PG_CTRL2_O, // power good control second
  output logic SW_RESET_O, // software reset pulse
  output logic [7:0] MASK_TOP1_O, // top mask first
  output logic MASK_TOP2_O, // top mask second
  output logic [7:0] MASK_SW_O, // switcher masks
  output logic [7:0] MASK_LIN_O, // linear masks
  output logic ILOAD_SEL_O // load current channel select
);
  import pmcrb_pkg::*;
  logic [3:0] sw0_ctrl_reg;
  logic [7:0] otp_version_reg, pg_ctrl1_reg, int_top1_reg, int_sw_reg;
  logic [7:0] int_lin_reg, mask_top1_reg, mask_sw_reg, mask_lin_reg;
  logic [7:0] rdata_reg, rdata_next, rmask_reg, rmask_next;
  logic [2:0] pg_ctrl2_reg;
  logic sw_reset_reg, int_top2_reg, mask_top2_reg, iload_sel_reg;
  logic rvalid_reg, fpwm_reg, enable_reg, discharge_reg;
  // write strobe for one offset; callers gate it with the clock enable
  function automatic logic wr_hit(input pmcrb_req_type r,
                                  input logic [7:0] ofs);
    wr_hit = r.wr && (r.addr == ofs);
  endfunction
  // sticky flag update; a new event outranks a clear in the same cycle
  function automatic logic [7:0] sticky(input logic [7:0] cur,
                                        input logic [7:0] set,
                                        input logic clr_en,
                                        input logic [7:0] clr,
                                        input logic [7:0] msk);
    logic [7:0] c;
    c = clr_en ? clr : `PMCRB_MSK_NONE;
    sticky = ((cur & ~c) | set) & msk;
  endfunction
  // switcher 0 control, reset value first, otp copy then overrides
  always_ff @(posedge MCLK_I) begin
    if (RESET_I) begin
      sw0_ctrl_reg <= `PMCRB_RST_SW0_CTRL;
    end else if (CE_I) begin
      if (OTP_LOAD_I) begin
        sw0_ctrl_reg <= OTP_I.sw0_ctrl;
      end else if (wr_hit(REQ_I, `PMCRB_OFS_SW0_CTRL)) begin
        sw0_ctrl_reg <= REQ_I.wdata[3:0];
      end
    end
  end
  // otp version code, only the otp read state writes it
  always_ff @(posedge MCLK_I) begin
    if (RESET_I) begin
      otp_version_reg <= `PMCRB_RST_OTHER;
    end else if (CE_I && OTP_LOAD_I) begin
      otp_version_reg <= OTP_I.version;
    end
  end
  // plain control registers, reserved bits never stored
  always_ff @(posedge MCLK_I) begin
    if (RESET_I) begin
      pg_ctrl1_reg <= `PMCRB_RST_OTHER;
      pg_ctrl2_reg <= 3'(`PMCRB_RST_OTHER);
      mask_top1_reg <= `PMCRB_RST_OTHER;
      mask_top2_reg <= `PMCRB_RST_ILOAD_SEL;
      mask_sw_reg <= `PMCRB_RST_OTHER;
      mask_lin_reg <= `PMCRB_RST_OTHER;
      iload_sel_reg <= `PMCRB_RST_ILOAD_SEL;
    end else if (CE_I) begin
      if (wr_hit(REQ_I, `PMCRB_OFS_PG_CTRL1)) begin
        pg_ctrl1_reg <= REQ_I.wdata & `PMCRB_MSK_PG_CTRL1;
      end
      if (wr_hit(REQ_I, `PMCRB_OFS_PG_CTRL2)) begin
        pg_ctrl2_reg <= REQ_I.wdata[2:0];
      end
      if (wr_hit(REQ_I, `PMCRB_OFS_MASK_TOP1)) begin
        mask_top1_reg <= REQ_I.wdata & `PMCRB_MSK_MASK_TOP1;
      end
      if (wr_hit(REQ_I, `PMCRB_OFS_MASK_TOP2)) begin
        mask_top2_reg <= REQ_I.wdata[0];
      end
      if (wr_hit(REQ_I, `PMCRB_OFS_MASK_SW)) begin
        mask_sw_reg <= REQ_I.wdata & `PMCRB_MSK_STAT_CH;
      end
      if (wr_hit(REQ_I, `PMCRB_OFS_MASK_LIN)) begin
        mask_lin_reg <= REQ_I.wdata & `PMCRB_MSK_STAT_CH;
      end
      if (wr_hit(REQ_I, `PMCRB_OFS_ILOAD_SEL)) begin
        iload_sel_reg <= REQ_I.wdata[0];
      end
    end
  end
  // software reset bit self-clears one cycle after a write of one ends, so a stuck write holds reset
  always_ff @(posedge MCLK_I) begin
    if (RESET_I) begin
      sw_reset_reg <= 1'b0;
    end else if (CE_I) begin
      sw_reset_reg <= wr_hit(REQ_I, `PMCRB_OFS_SW_RESET) && REQ_I.wdata[0];
    end
  end
  // interrupt flags, write one to clear
  always_ff @(posedge MCLK_I) begin
    if (RESET_I) begin
      int_top1_reg <= `PMCRB_RST_OTHER;
      int_top2_reg <= 1'b0;
      int_sw_reg <= `PMCRB_RST_OTHER;
      int_lin_reg <= `PMCRB_RST_OTHER;
    end else if (CE_I) begin
      int_top1_reg <= sticky(int_top1_reg, EVT_I.top1,
        wr_hit(REQ_I, `PMCRB_OFS_INT_TOP1), REQ_I.wdata,
        `PMCRB_MSK_INT_TOP1);
      int_top2_reg <= EVT_I.top2 || (int_top2_reg &&
        !(wr_hit(REQ_I, `PMCRB_OFS_INT_TOP2) && REQ_I.wdata[0]));
      int_sw_reg <= sticky(int_sw_reg, EVT_I.sw,
        wr_hit(REQ_I, `PMCRB_OFS_INT_SW), REQ_I.wdata,
        `PMCRB_MSK_INT_CH);
      int_lin_reg <= sticky(int_lin_reg, EVT_I.lin,
        wr_hit(REQ_I, `PMCRB_OFS_INT_LIN), REQ_I.wdata,
        `PMCRB_MSK_INT_CH);
    end
  end
  // read decode; unmapped offsets read as zero
  always_comb begin
    rdata_next = `PMCRB_RST_OTHER;
    rmask_next = `PMCRB_MSK_NONE;
    if (REQ_I.addr == `PMCRB_OFS_DEV_ID) begin
      rdata_next = {PART_ID, 6'h00};
      rmask_next = `PMCRB_MSK_DEV_ID;
    end else if (REQ_I.addr == `PMCRB_OFS_OTP_VER) begin
      rdata_next = otp_version_reg;
      rmask_next = `PMCRB_MSK_ALL;
    end else if (REQ_I.addr == `PMCRB_OFS_SW0_CTRL) begin
      rdata_next = {4'h0, sw0_ctrl_reg};
      rmask_next = `PMCRB_MSK_SW0_CTRL;
    end else if (REQ_I.addr == `PMCRB_OFS_PG_CTRL1) begin
      rdata_next = pg_ctrl1_reg;
      rmask_next = `PMCRB_MSK_PG_CTRL1;
    end else if (REQ_I.addr == `PMCRB_OFS_PG_CTRL2) begin
      rdata_next = {5'h00, pg_ctrl2_reg};
      rmask_next = `PMCRB_MSK_PG_CTRL2;
    end else if (REQ_I.addr == `PMCRB_OFS_POWER_GOOD_FAULT_FLAGS) begin
      rdata_next = {4'h0, STAT_I.power_good_fault_flags};
      rmask_next = `PMCRB_MSK_POWER_GOOD_FAULT_FLAGS;
    end else if (REQ_I.addr == `PMCRB_OFS_SW_RESET) begin
      rmask_next = `PMCRB_MSK_SW_RESET;
    end else if (REQ_I.addr == `PMCRB_OFS_INT_TOP1) begin
      rdata_next = int_top1_reg;
      rmask_next = `PMCRB_MSK_INT_TOP1;
    end else if (REQ_I.addr == `PMCRB_OFS_INT_TOP2) begin
      rdata_next = {7'h00, int_top2_reg};
      rmask_next = `PMCRB_MSK_BIT0;
    end else if (REQ_I.addr == `PMCRB_OFS_INT_SW) begin
      rdata_next = int_sw_reg;
      rmask_next = `PMCRB_MSK_INT_CH;
    end else if (REQ_I.addr == `PMCRB_OFS_INT_LIN) begin
      rdata_next = int_lin_reg;
      rmask_next = `PMCRB_MSK_INT_CH;
    end else if (REQ_I.addr == `PMCRB_OFS_STAT_TOP) begin
      rdata_next = STAT_I.top & `PMCRB_MSK_STAT_TOP;
      rmask_next = `PMCRB_MSK_STAT_TOP;
    end else if (REQ_I.addr == `PMCRB_OFS_STAT_SW) begin
      rdata_next = STAT_I.sw & `PMCRB_MSK_STAT_CH;
      rmask_next = `PMCRB_MSK_STAT_CH;
    end else if (REQ_I.addr == `PMCRB_OFS_STAT_LIN) begin
      rdata_next = STAT_I.lin & `PMCRB_MSK_STAT_CH;
      rmask_next = `PMCRB_MSK_STAT_CH;
    end else if (REQ_I.addr == `PMCRB_OFS_MASK_TOP1) begin
      rdata_next = mask_top1_reg;
      rmask_next = `PMCRB_MSK_MASK_TOP1;
    end else if (REQ_I.addr == `PMCRB_OFS_MASK_TOP2) begin
      rdata_next = {7'h00, mask_top2_reg};
      rmask_next = `PMCRB_MSK_BIT0;
    end else if (REQ_I.addr == `PMCRB_OFS_MASK_SW) begin
      rdata_next = mask_sw_reg;
      rmask_next = `PMCRB_MSK_STAT_CH;
    end else if (REQ_I.addr == `PMCRB_OFS_MASK_LIN) begin
      rdata_next = mask_lin_reg;
      rmask_next = `PMCRB_MSK_STAT_CH;
    end else if (REQ_I.addr == `PMCRB_OFS_ILOAD_SEL) begin
      rdata_next = {7'h00, iload_sel_reg};
      rmask_next = `PMCRB_MSK_BIT0;
    end else if (REQ_I.addr == `PMCRB_OFS_ILOAD_HI) begin
      rdata_next = {7'h00, STAT_I.iload[8]};
      rmask_next = `PMCRB_MSK_BIT0;
    end else if (REQ_I.addr == `PMCRB_OFS_ILOAD_LO) begin
      rdata_next = STAT_I.iload[7:0];
      rmask_next = `PMCRB_MSK_ALL;
    end
  end
  // registered read answer, one cycle after the strobe
  always_ff @(posedge MCLK_I) begin
    if (RESET_I) begin
      rdata_reg <= `PMCRB_RST_OTHER;
      rvalid_reg <= 1'b0;
      rmask_reg <= `PMCRB_MSK_NONE;
    end else if (CE_I) begin
      rvalid_reg <= REQ_I.rd;
      if (REQ_I.rd) begin
        rdata_reg <= rdata_next;
        rmask_reg <= rmask_next;
      end
    end
  end
  // regulator controls, registered so the analog side sees clean levels
  always_ff @(posedge MCLK_I) begin
    if (RESET_I) begin
      fpwm_reg <= 1'b0;
      enable_reg <= 1'b0;
      discharge_reg <= 1'b0;
    end else if (CE_I) begin
      fpwm_reg <= sw0_ctrl_reg[`PMCRB_BIT_FPWM];
      enable_reg <= sw0_ctrl_reg[`PMCRB_BIT_SWEN] &&
        (!sw0_ctrl_reg[`PMCRB_BIT_ENSRC] || EN_PIN_I);
      discharge_reg <= sw0_ctrl_reg[`PMCRB_BIT_DISCH] &&
        !(sw0_ctrl_reg[`PMCRB_BIT_SWEN] &&
          (!sw0_ctrl_reg[`PMCRB_BIT_ENSRC] || EN_PIN_I));
    end
  end
  assign RDATA_O = rdata_reg;
  assign RVALID_O = rvalid_reg;
  assign SW0_FORCED_PWM_O = fpwm_reg;
  assign SW0_ENABLE_O = enable_reg;
  assign SW0_DISCHARGE_O = discharge_reg;
  assign PG_CTRL1_O = pg_ctrl1_reg;
  assign PG_CTRL2_O = pg_ctrl2_reg;
  assign SW_RESET_O = sw_reset_reg;
  assign MASK_TOP1_O = mask_top1_reg;
  assign MASK_TOP2_O = mask_top2_reg;
  assign MASK_SW_O = mask_sw_reg;
  assign MASK_LIN_O = mask_lin_reg;
  assign ILOAD_SEL_O = iload_sel_reg;
  // identification read returns the part code over zeros
  property p_part_id;
    @(posedge MCLK_I) disable iff (RESET_I)
    (CE_I && REQ_I.rd && REQ_I.addr == `PMCRB_OFS_DEV_ID) |=>
      (RDATA_O == {PART_ID, 6'h00}) && RVALID_O;
  endproperty
  a_part_id: assert property (p_part_id)
    else $error("part code read wrong");
  // otp version read matches what the otp read state loaded
  property p_otp_ver;
    @(posedge MCLK_I) disable iff (RESET_I)
    (CE_I && OTP_LOAD_I) ##1 (CE_I && REQ_I.rd && !OTP_LOAD_I &&
      REQ_I.addr == `PMCRB_OFS_OTP_VER) |=>
      RDATA_O == $past(OTP_I.version, 2);
  endproperty
  a_otp_ver: assert property (p_otp_ver)
    else $error("otp version read wrong");
  // forced pwm bit reaches the output two cycles after the write
  property p_fpwm;
    @(posedge MCLK_I) disable iff (RESET_I)
    (CE_I && !OTP_LOAD_I && wr_hit(REQ_I, `PMCRB_OFS_SW0_CTRL))
      ##1 CE_I |=> SW0_FORCED_PWM_O == $past(REQ_I.wdata[3], 2);
  endproperty
  a_fpwm: assert property (p_fpwm)
    else $error("forced pwm not applied");
  // discharge follows its bit, but only while the switcher is off
  property p_disch;
    @(posedge MCLK_I) disable iff (RESET_I)
    CE_I |=> SW0_DISCHARGE_O ==
      ($past(sw0_ctrl_reg[`PMCRB_BIT_DISCH]) && !SW0_ENABLE_O);
  endproperty
  a_disch: assert property (p_disch)
    else $error("discharge while enabled");
  // with pin control the pin low keeps the switcher off
  property p_ensrc;
    @(posedge MCLK_I) disable iff (RESET_I)
    (CE_I && sw0_ctrl_reg[`PMCRB_BIT_ENSRC] && !EN_PIN_I) |=>
      !SW0_ENABLE_O;
  endproperty
  a_ensrc: assert property (p_ensrc)
    else $error("pin ignored by enable");
  // software enable alone turns the switcher on without pin control
  property p_swen;
    @(posedge MCLK_I) disable iff (RESET_I)
    (CE_I && !sw0_ctrl_reg[`PMCRB_BIT_ENSRC]) |=>
      SW0_ENABLE_O == $past(sw0_ctrl_reg[`PMCRB_BIT_SWEN]);
  endproperty
  a_swen: assert property (p_swen)
    else $error("software enable not followed");
  // every read strobe answers exactly one cycle later
  property p_read;
    @(posedge MCLK_I) disable iff (RESET_I)
    (CE_I && REQ_I.rd) |=> RVALID_O ##1 (!$past(CE_I) ||
      $past(REQ_I.rd) || !RVALID_O);
  endproperty
  a_read: assert property (p_read)
    else $error("read answer timing wrong");
  // otp read state overwrites the switcher control defaults
  property p_otp_load;
    @(posedge MCLK_I) disable iff (RESET_I)
    (CE_I && OTP_LOAD_I) |=> sw0_ctrl_reg == $past(OTP_I.sw0_ctrl);
  endproperty
  a_otp_load: assert property (p_otp_load)
    else $error("otp defaults not loaded");
  // reserved bits of any answer are zero
  property p_reserved;
    @(posedge MCLK_I) disable iff (RESET_I)
    RVALID_O |-> (RDATA_O & ~rmask_reg) == 8'h00;
  endproperty
  a_reserved: assert property (p_reserved)
    else $error("reserved bits not zero");
  // an event during a clear still leaves its flag set
  property p_set_wins;
    @(posedge MCLK_I) disable iff (RESET_I)
    (CE_I && EVT_I.sw[0]) |=> int_sw_reg[0];
  endproperty
  a_set_wins: assert property (p_set_wins)
    else $error("event lost against clear");
endmodule

/* testbench.sv */
// self-checking bench for the power device register bank
`timescale 1ns/1ps
`include "pmcrb_defines.svh"
module testbench;
  import pmcrb_pkg::*;
  localparam logic [1:0] PART = 2'h3; // arbitrary part code
  logic mclk, reset, ce, otp_load, en_pin, rvalid;
  logic fpwm, sw_en, disch, sw_reset, mask_top2, iload_sel;
  logic [7:0] rdata, pg1, mtop1, msw, mlin;
  logic [2:0] pg2;
  pmcrb_req_type req;
  pmcrb_otp_type otp;
  pmcrb_stat_type stat;
  pmcrb_evt_type evt;
  int fails = 0;
  int check_count = 0;
  int cycles = 0;
  pmcrb_top #(.PART_ID(PART)) dut_u (.MCLK_I(mclk), .RESET_I(reset),
    .CE_I(ce), .REQ_I(req), .RDATA_O(rdata), .RVALID_O(rvalid),
    .OTP_LOAD_I(otp_load), .OTP_I(otp), .STAT_I(stat), .EVT_I(evt),
    .EN_PIN_I(en_pin), .SW0_FORCED_PWM_O(fpwm), .SW0_ENABLE_O(sw_en),
    .SW0_DISCHARGE_O(disch), .PG_CTRL1_O(pg1), .PG_CTRL2_O(pg2),
    .SW_RESET_O(sw_reset), .MASK_TOP1_O(mtop1), .MASK_TOP2_O(mask_top2),
    .MASK_SW_O(msw), .MASK_LIN_O(mlin), .ILOAD_SEL_O(iload_sel));
  pmcrb_host_model host_u (.clk_i(mclk), .req_o(req), .rdata_i(rdata),
    .rvalid_i(rvalid));
  // 4 ns clock
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  // compare and count
  task automatic check(input string name, input logic [7:0] seen,
                       input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // read through the host and expect a valid pulse with the value
  task automatic rd_check(input logic [7:0] a, input logic [7:0] exp,
                          input string name);
    logic [7:0] d;
    logic v;
    host_u.read_reg(a, d, v);
    check({name, " valid"}, {7'h00, v}, 8'h01);
    check(name, d, exp);
  endtask
  // switcher 0 outputs against the expected triple
  task automatic check_sw0(input logic f, input logic e, input logic dis);
    check("forced pwm", {7'h00, fpwm}, {7'h00, f});
    check("enable", {7'h00, sw_en}, {7'h00, e});
    check("discharge", {7'h00, disch}, {7'h00, dis});
  endtask
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // defaults straight out of reset, pin high
  task automatic test_reset_values;
    rd_check(`PMCRB_OFS_DEV_ID, {PART, 6'h00}, "part code");
    rd_check(`PMCRB_OFS_OTP_VER, 8'h00, "otp version");
    rd_check(`PMCRB_OFS_SW0_CTRL, 8'h07, "sw0 ctrl");
    check_sw0(1'b0, 1'b1, 1'b0);
  endtask
  // writes to read-only places change nothing
  task automatic test_read_only;
    stat.power_good_fault_flags = 4'h5;
    stat.iload = 9'h1a5;
    host_u.write_reg(`PMCRB_OFS_DEV_ID, 8'hff);
    rd_check(`PMCRB_OFS_DEV_ID, {PART, 6'h00}, "part code");
    host_u.write_reg(`PMCRB_OFS_OTP_VER, 8'hff);
    rd_check(`PMCRB_OFS_OTP_VER, 8'h00, "otp version");
    host_u.write_reg(`PMCRB_OFS_POWER_GOOD_FAULT_FLAGS, 8'hff);
    rd_check(`PMCRB_OFS_POWER_GOOD_FAULT_FLAGS, 8'h05, "power_good_fault_flags");
    rd_check(`PMCRB_OFS_ILOAD_LO, 8'ha5, "load low");
    rd_check(`PMCRB_OFS_ILOAD_HI, 8'h01, "load high");
    stat.sw = 8'hff;
    stat.top = 8'hff;
    rd_check(`PMCRB_OFS_STAT_SW, 8'hdd, "sw status");
    rd_check(`PMCRB_OFS_STAT_TOP, 8'h86, "top status");
  endtask
  // otp strobe replaces defaults and version code
  task automatic test_otp_load;
    @(posedge mclk);
    #1 otp = '{sw0_ctrl: 4'h8, version: 8'h3c};
    otp_load = 1'b1;
    // read issued in the cycle right after the load strobe
    fork
      rd_check(`PMCRB_OFS_OTP_VER, 8'h3c, "otp version");
      begin
        @(posedge mclk);
        #1 otp_load = 1'b0;
      end
    join
    rd_check(`PMCRB_OFS_SW0_CTRL, 8'h08, "sw0 ctrl");
    check_sw0(1'b1, 1'b0, 1'b0);
  endtask
  // every control nibble under both pin levels, reserved bits set too
  task automatic test_ctrl_table;
    logic [3:0] f;
    logic e;
    for (int p = 0; p < 2; p++) begin
      for (int v = 0; v < 16; v++) begin
        f = v[3:0];
        e = f[0] & (~f[1] | p[0]);
        @(posedge mclk);
        #1 en_pin = p[0];
        host_u.write_reg(`PMCRB_OFS_SW0_CTRL, {4'hf, f});
        rd_check(`PMCRB_OFS_SW0_CTRL, {4'h0, f}, "sw0 ctrl");
        check_sw0(f[3], e, f[2] & ~e);
      end
    end
  endtask
  // other writable registers, reserved bits and unmapped places
  task automatic test_other_regs;
    host_u.write_reg(`PMCRB_OFS_PG_CTRL1, 8'hff);
    rd_check(`PMCRB_OFS_PG_CTRL1, 8'hdf, "pg ctrl1");
    check("pg ctrl1 out", pg1, 8'hdf);
    host_u.write_reg(`PMCRB_OFS_PG_CTRL2, 8'hff);
    check("pg ctrl2 out", {5'h00, pg2}, 8'h07);
    // a write while the clock enable is low must not land
    @(posedge mclk);
    #1 ce = 1'b0;
    host_u.write_reg(`PMCRB_OFS_PG_CTRL2, 8'h00);
    ce = 1'b1;
    rd_check(`PMCRB_OFS_PG_CTRL2, 8'h07, "pg ctrl2 frozen");
    host_u.write_reg(`PMCRB_OFS_MASK_TOP1, 8'hff);
    check("mask top1 out", mtop1, 8'h95);
    host_u.write_reg(`PMCRB_OFS_MASK_SW, 8'hff);
    rd_check(`PMCRB_OFS_MASK_SW, 8'hdd, "mask sw");
    host_u.write_reg(`PMCRB_OFS_MASK_LIN, 8'hff);
    check("mask lin out", mlin, 8'hdd);
    check("mask sw out", msw, 8'hdd);
    host_u.write_reg(`PMCRB_OFS_MASK_TOP2, 8'hff);
    rd_check(`PMCRB_OFS_MASK_TOP2, 8'h01, "mask top2");
    check("mask top2 out", {7'h00, mask_top2}, 8'h01);
    host_u.write_reg(`PMCRB_OFS_ILOAD_SEL, 8'hff);
    rd_check(`PMCRB_OFS_ILOAD_SEL, 8'h01, "load select");
    check("load select out", {7'h00, iload_sel}, 8'h01);
    host_u.write_reg(`PMCRB_OFS_SW_RESET, 8'h01);
    check("sw reset pulse", {7'h00, sw_reset}, 8'h01);
    rd_check(`PMCRB_OFS_SW_RESET, 8'h00, "sw reset");
    check("sw reset end", {7'h00, sw_reset}, 8'h00);
    rd_check(8'h03, 8'h00, "unmapped 03");
    rd_check(8'h40, 8'h00, "unmapped 40");
  endtask
  // sticky flag set by an event, cleared by writing one
  task automatic test_flags;
    @(posedge mclk);
    #1 evt = '{top1: 8'h00, top2: 1'b1, sw: 8'h01, lin: 8'hff};
    @(posedge mclk);
    #1 evt = '0;
    rd_check(`PMCRB_OFS_INT_SW, 8'h01, "sw flag");
    rd_check(`PMCRB_OFS_INT_SW, 8'h01, "sw flag kept");
    rd_check(`PMCRB_OFS_INT_LIN, 8'h77, "lin flags");
    rd_check(`PMCRB_OFS_INT_TOP2, 8'h01, "top2 flag");
    host_u.write_reg(`PMCRB_OFS_INT_SW, 8'h01);
    rd_check(`PMCRB_OFS_INT_SW, 8'h00, "sw flag clear");
    // event in the same cycle as its clear keeps the flag
    fork
      host_u.write_reg(`PMCRB_OFS_INT_SW, 8'h01);
      begin
        @(posedge mclk);
        #1 evt.sw = 8'h01;
        @(posedge mclk);
        #1 evt.sw = 8'h00;
      end
    join
    rd_check(`PMCRB_OFS_INT_SW, 8'h01, "sw flag set wins");
  endtask
  // hang guard, far above the few hundred cycles the run needs
  always @(posedge mclk) begin
    cycles++;
    if (cycles > 5000) begin
      fails++;
      finish_test;
    end
  end
  initial begin
    reset = 1'b1;
    ce = 1'b1;
    otp_load = 1'b0;
    en_pin = 1'b1;
    otp = '0;
    stat = '0;
    evt = '0;
    repeat (5) @(posedge mclk);
    #1 reset = 1'b0;
    test_reset_values;
    test_read_only;
    test_otp_load;
    test_ctrl_table;
    test_other_regs;
    test_flags;
    finish_test;
  end
endmodule
